// ### rtl/gds_defines.vh
`ifndef GDS_DEFINES_VH
`define GDS_DEFINES_VH

// apb register byte offsets
`define GDS_OFS_CURRENT      8'h00
`define GDS_OFS_TIMING       8'h04
`define GDS_OFS_LEVEL        8'h08
`define GDS_OFS_STATUS       8'h0C

// current register fields
`define GDS_HS_ON_LSB        0
`define GDS_HS_OFF_LSB       4
`define GDS_LS_ON_LSB        8
`define GDS_LS_OFF_LSB       12
`define GDS_PRE_ON_LSB       16
`define GDS_PRE_OFF_LSB      24

// timing register fields, one byte each
`define GDS_T1_LSB           0
`define GDS_T2_LSB           8
`define GDS_T3_LSB           16
`define GDS_T4_LSB           24

// reset values
`define GDS_CURRENT_RST      32'h0000_0000
`define GDS_TIMING_RST       32'h0000_0000
`define GDS_LEVEL_RST        2'h2

// drive current code standing for full strength (1.5 A)
`define GDS_CODE_FULL        5'h10

// interval limits
`define GDS_CLK_PERIOD_NS    25
`define GDS_T13_MAX_NS       2590
`define GDS_T24_MAX_NS       2550
// longest intervals in clock cycles, the ns limits divided by the 25 ns clock period (rounded down)
`define GDS_T13_MAX_CYC      8'h67
`define GDS_T24_MAX_CYC      8'h66

`endif

// ### rtl/gds_sequencer.v
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "gds_defines.vh"

module gds_sequencer (
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [2:0]  high_side_input,
  input  wire [2:0]  low_side_input,
  output reg  [14:0] high_side_current,
  output reg  [2:0]  high_side_sourcing,
  output reg  [14:0] low_side_current,
  output reg  [2:0]  low_side_sourcing,
  output reg  [1:0]  gate_drive_level_select
);

  localparam [5:0] ST_OFF     = 6'b000001;
  localparam [5:0] ST_PRE_ON  = 6'b000010;
  localparam [5:0] ST_CTL_ON  = 6'b000100;
  localparam [5:0] ST_FULL_ON = 6'b001000;
  localparam [5:0] ST_PRE_OFF = 6'b010000;
  localparam [5:0] ST_CTL_OFF = 6'b100000;

  reg  [31:0] current_q;
  reg  [31:0] timing_q;
  reg  [5:0]  in_prev_q;
  reg  [35:0] st_q;
  reg  [35:0] st_d;
  reg  [47:0] cnt_q;
  reg  [47:0] cnt_d;
  reg  [31:0] rdata_d;
  reg         hit_d;
  wire [5:0]  drv_in;
  wire [7:0]  t1;
  wire [7:0]  t2;
  wire [7:0]  t3;
  wire [7:0]  t4;
  wire        wr_en;
  wire [5:0]  rise;
  wire [5:0]  fall;
  reg  [29:0] code_d;
  reg  [5:0]  src_d;
  integer     i;
  integer     k;

  assign drv_in = {low_side_input, high_side_input};
  assign wr_en  = psel & penable & pwrite;
  // registers answer at once; no wait state is ever inserted
  assign pready = 1'b1;
  // edges against last cycle's sample; an input already high at release counts as a rise
  assign rise   = drv_in & ~in_prev_q;
  assign fall   = ~drv_in & in_prev_q;

  // limit an interval code to the longest supported duration
  function [7:0] gds_clamp;
    input [7:0] code;
    input [7:0] lim;
    begin
      gds_clamp = (code > lim) ? lim : code;
    end
  endfunction

  // one interval setting per segment, shared by all drivers
  assign t1 = gds_clamp(timing_q[`GDS_T1_LSB +: 8], `GDS_T13_MAX_CYC);
  assign t2 = gds_clamp(timing_q[`GDS_T2_LSB +: 8], `GDS_T24_MAX_CYC);
  assign t3 = gds_clamp(timing_q[`GDS_T3_LSB +: 8], `GDS_T13_MAX_CYC);
  assign t4 = gds_clamp(timing_q[`GDS_T4_LSB +: 8], `GDS_T24_MAX_CYC);

  // drive current code for a state; ls selects the low-side settings
  function [4:0] gds_code;
    input [5:0]  st;
    input        ls;
    input [31:0] cur;
    begin
      case (st)
        ST_PRE_ON: gds_code = cur[`GDS_PRE_ON_LSB +: 5];
        ST_CTL_ON: gds_code = ls ? {1'b0, cur[`GDS_LS_ON_LSB +: 4]}
                                 : {1'b0, cur[`GDS_HS_ON_LSB +: 4]};
        ST_PRE_OFF: gds_code = cur[`GDS_PRE_OFF_LSB +: 5];
        ST_CTL_OFF: gds_code = ls ? {1'b0, cur[`GDS_LS_OFF_LSB +: 4]}
                                  : {1'b0, cur[`GDS_HS_OFF_LSB +: 4]};
        default: gds_code = `GDS_CODE_FULL; // full source when on, strong pull-down when off
      endcase
    end
  endfunction

  // code values above full strength are not defined; cap them
  function [4:0] gds_cap;
    input [4:0] code;
    begin
      gds_cap = (code > `GDS_CODE_FULL) ? `GDS_CODE_FULL : code;
    end
  endfunction

  // sourcing states pull the gate up; every other state sinks
  function gds_is_on;
    input [5:0] st;
    begin
      gds_is_on = |(st & (ST_PRE_ON | ST_CTL_ON | ST_FULL_ON));
    end
  endfunction

  // status word: busy flag and sampled input per driver
  function [31:0] gds_status;
    input [35:0] st;
    input [5:0]  smp;
    integer      n;
    begin
      gds_status = 32'h0000_0000;
      for (n = 0; n < 6; n = n + 1) begin
        gds_status[n]     = ~st[n*6];
        gds_status[8 + n] = smp[n];
      end
    end
  endfunction

  // sequencer next state, one per driver
  always @* begin
    st_d  = st_q;
    cnt_d = cnt_q;
    for (i = 0; i < 6; i = i + 1) begin
      if (rise[i]) begin
        // any edge restarts, even mid-sequence
        // the counter is reloaded, so no count of the abandoned segment survives
        if (t1 != 8'h00) begin
          st_d[i*6 +: 6]  = ST_PRE_ON;
          cnt_d[i*8 +: 8] = t1;
        end else if (t2 != 8'h00) begin
          st_d[i*6 +: 6]  = ST_CTL_ON;
          cnt_d[i*8 +: 8] = t2;
        end else begin
          st_d[i*6 +: 6]  = ST_FULL_ON;
          cnt_d[i*8 +: 8] = 8'h00;
        end
      end else if (fall[i]) begin
        if (t3 != 8'h00) begin
          st_d[i*6 +: 6]  = ST_PRE_OFF;
          cnt_d[i*8 +: 8] = t3;
        end else if (t4 != 8'h00) begin
          st_d[i*6 +: 6]  = ST_CTL_OFF;
          cnt_d[i*8 +: 8] = t4;
        end else begin
          st_d[i*6 +: 6]  = ST_OFF;
          cnt_d[i*8 +: 8] = 8'h00;
        end
      end else begin
        case (st_q[i*6 +: 6])
          ST_PRE_ON: begin
            if (cnt_q[i*8 +: 8] == 8'h01) begin
              // next segment starts in the same edge, no gap
              st_d[i*6 +: 6]  = (t2 != 8'h00) ? ST_CTL_ON : ST_FULL_ON;
              cnt_d[i*8 +: 8] = t2;
            end else begin
              cnt_d[i*8 +: 8] = cnt_q[i*8 +: 8] - 8'h01;
            end
          end
          ST_CTL_ON: begin
            if (cnt_q[i*8 +: 8] == 8'h01) begin
              st_d[i*6 +: 6]  = ST_FULL_ON;
              cnt_d[i*8 +: 8] = 8'h00;
            end else begin
              cnt_d[i*8 +: 8] = cnt_q[i*8 +: 8] - 8'h01;
            end
          end
          ST_PRE_OFF: begin
            if (cnt_q[i*8 +: 8] == 8'h01) begin
              st_d[i*6 +: 6]  = (t4 != 8'h00) ? ST_CTL_OFF : ST_OFF;
              cnt_d[i*8 +: 8] = t4;
            end else begin
              cnt_d[i*8 +: 8] = cnt_q[i*8 +: 8] - 8'h01;
            end
          end
          ST_CTL_OFF: begin
            if (cnt_q[i*8 +: 8] == 8'h01) begin
              st_d[i*6 +: 6]  = ST_OFF;
              cnt_d[i*8 +: 8] = 8'h00;
            end else begin
              cnt_d[i*8 +: 8] = cnt_q[i*8 +: 8] - 8'h01;
            end
          end
          ST_FULL_ON: begin
            st_d[i*6 +: 6] = ST_FULL_ON; // no timeout, so 100 % duty holds
          end
          ST_OFF: begin
            st_d[i*6 +: 6] = ST_OFF;
          end
          default: begin
            // a corrupt state word falls back to off rather than locking the driver
            st_d[i*6 +: 6]  = ST_OFF;
            cnt_d[i*8 +: 8] = 8'h00;
          end
        endcase
      end
    end
  end

  // output codes from the next state, so outputs move on the edge that samples the input
  always @* begin
    code_d = 30'h0;
    src_d  = 6'h00;
    for (k = 0; k < 6; k = k + 1) begin
      code_d[k*5 +: 5] = gds_cap(gds_code(st_d[k*6 +: 6], k >= 3, current_q));
      src_d[k]         = gds_is_on(st_d[k*6 +: 6]);
    end
  end

  // drivers and their registered outputs
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      in_prev_q          <= 6'h00;
      st_q               <= {6{ST_OFF}};
      cnt_q              <= 48'h0000_0000_0000;
      // reset leaves every gate on strong sink
      high_side_current  <= {3{`GDS_CODE_FULL}};
      low_side_current   <= {3{`GDS_CODE_FULL}};
      high_side_sourcing <= 3'h0;
      low_side_sourcing  <= 3'h0;
    end else begin
      in_prev_q <= drv_in;
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      high_side_current  <= code_d[14:0];
      low_side_current   <= code_d[29:15];
      high_side_sourcing <= src_d[2:0];
      low_side_sourcing  <= src_d[5:3];
    end
  end

  // apb register file, zero wait states
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      current_q               <= `GDS_CURRENT_RST;
      timing_q                <= `GDS_TIMING_RST;
      gate_drive_level_select <= `GDS_LEVEL_RST; // twelve-volt code
    end else if (wr_en) begin
      case (paddr)
        // reserved current bits kept zero so a read shows only the bits the drivers use
        `GDS_OFS_CURRENT: current_q <= pwdata & 32'h1F1F_FFFF;
        // limitation: a new interval reaches a driver only at its next segment load
        `GDS_OFS_TIMING:  timing_q  <= pwdata;
        `GDS_OFS_LEVEL:   gate_drive_level_select <= pwdata[1:0];
        default: begin
        end
      endcase
    end
  end

  always @* begin
    hit_d   = 1'b1;
    rdata_d = 32'h0000_0000;
    case (paddr)
      `GDS_OFS_CURRENT: rdata_d = current_q;
      `GDS_OFS_TIMING:  rdata_d = timing_q;
      `GDS_OFS_LEVEL:   rdata_d = {30'h0, gate_drive_level_select};
      `GDS_OFS_STATUS:  rdata_d = gds_status(st_q, in_prev_q);
      default: hit_d = 1'b0;
    endcase
  end

  // read data captured in the setup cycle so it leaves a flip-flop
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rdata_d;
    end
  end

  // pslverr marks unmapped offsets; writes to them are dropped
  assign pslverr = psel & penable & ~hit_d;

endmodule // gds_sequencer

// ### sim/gds_pwm_model.sv
`timescale 1ns/100ps
module gds_pwm_model (
  input  wire       clk_sys,
  input  wire       reset_n,
  input  wire [2:0] hs_req,
  input  wire [2:0] ls_req,
  input  wire [7:0] dead,
  output reg  [2:0] hs,
  output reg  [2:0] ls
);
  // a phase turns on only after both of its outputs idled for dead cycles
  reg [7:0] idle_q [0:2];
  integer   i;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hs <= 3'h0;
      ls <= 3'h0;
      for (i = 0; i < 3; i = i + 1) idle_q[i] <= 8'h00;
    end else begin
      for (i = 0; i < 3; i = i + 1) begin
        idle_q[i] <= (hs[i] | ls[i]) ? 8'h00 : idle_q[i] + {7'h00, idle_q[i] != 8'hFF};
        hs[i] <= hs_req[i] & ~ls_req[i] & (hs[i] | (~ls[i] & idle_q[i] >= dead));
        ls[i] <= ls_req[i] & ~hs_req[i] & (ls[i] | (~hs[i] & idle_q[i] >= dead));
      end
    end
  end
endmodule // gds_pwm_model

// ### sim/gds_seq_monitor.sv
`timescale 1ns/100ps
module gds_seq_monitor (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic [2:0]  high_side_input,
  input wire logic [2:0]  low_side_input,
  input wire logic [14:0] high_side_current,
  input wire logic [2:0]  high_side_sourcing,
  input wire logic [14:0] low_side_current,
  input wire logic [2:0]  low_side_sourcing,
  input wire logic [1:0]  gate_drive_level_select
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire acc = psel && penable;
  wire unm = !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C});
  sequence s_hs_rise; !high_side_input[0] ##1 high_side_input[0]; endsequence
  sequence s_ls_fall; low_side_input[2] ##1 !low_side_input[2]; endsequence
  a_rise_sources: assert property (s_hs_rise |=> high_side_sourcing[0])
    else $error("switch-on not started");
  a_fall_sinks: assert property (s_ls_fall |=> !low_side_sourcing[2])
    else $error("switch-off not started");
  a_abort_restart: assert property ($fell(high_side_input[1]) |=> !high_side_sourcing[1])
    else $error("sequence not abandoned");
  a_full_holds: assert property (high_side_input[0] && high_side_sourcing[0] && high_side_current[4:0] == 5'h10
    |=> high_side_sourcing[0] && high_side_current[4:0] == 5'h10) else $error("full drive lost");
  a_off_holds: assert property (!low_side_input[0] && !low_side_sourcing[0] && low_side_current[4:0] == 5'h10
    |=> !low_side_sourcing[0] && low_side_current[4:0] == 5'h10) else $error("off sink lost");
  a_on_stays: assert property (high_side_input[1] && high_side_sourcing[1] |=> high_side_sourcing[1])
    else $error("output dropped while input high");
  a_level_reset: assert property (!$past(reset_n) |-> gate_drive_level_select == 2'h2)
    else $error("level reset value wrong");
  a_level_write: assert property (acc && pwrite && paddr == 8'h08
    |=> gate_drive_level_select == $past(pwdata[1:0])) else $error("level not written");
  a_code_range: assert property (high_side_current[4:0] <= 5'h10 && low_side_current[4:0] <= 5'h10)
    else $error("current code out of range");
  a_err_map: assert property (pslverr == (acc && unm)) else $error("pslverr wrong");
endmodule // gds_seq_monitor

bind gds_sequencer gds_seq_monitor u_mon (.*);

// ### sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic        clk_sys = 1'h0;
  logic        reset_n = 1'h0;
  logic        psel    = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite  = 1'h0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0, rd;
  logic        er, ws  = 1'h0;
  logic [2:0]  hs_req  = 3'h0, ls_req = 3'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr;
  wire  [2:0]  hs_in, ls_in, hs_src, ls_src;
  wire  [14:0] hs_cur, ls_cur;
  wire  [1:0]  lvl;
  int          wp = 0, n_fail = 0, compares = 0, cyc = 0;
  wire  [4:0]  cur_w = ws ? ls_cur[wp*5+:5] : hs_cur[wp*5+:5];
  wire         src_w = ws ? ls_src[wp] : hs_src[wp];
  always #12.5 clk_sys = ~clk_sys;
  gds_pwm_model u_pwm (.clk_sys(clk_sys), .reset_n(reset_n), .hs_req(hs_req), .ls_req(ls_req), .dead(8'h06),
    .hs(hs_in), .ls(ls_in));
  gds_sequencer u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .high_side_input(hs_in),
    .low_side_input(ls_in), .high_side_current(hs_cur), .high_side_sourcing(hs_src), .low_side_current(ls_cur),
    .low_side_sourcing(ls_src), .gate_drive_level_select(lvl));
  task automatic print_verdict;
    if (n_fail == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do @(posedge clk_sys); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    #1;
  endtask
  task automatic cfg(input logic [31:0] c, input logic [31:0] t);
    apb(1'h1, 8'h00, c);
    apb(1'h1, 8'h04, t);
  endtask
  // checks one code per cycle; the model adds a cycle, so answers land two edges on
  task automatic run(input logic [4:0] code, input int n, input logic src);
    repeat (n) begin
      chk(cur_w, code);
      chk(src_w, src);
      @(posedge clk_sys);
      #1;
    end
  endtask
  task automatic go(input logic v);
    @(posedge clk_sys);
    if (ws) ls_req[wp] <= v;
    else hs_req[wp] <= v;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_regs;
    apb(1'h0, 8'h08, 32'h0);
    chk(rd, 32'h2);
    chk(lvl, 2'h2);
    for (int l = 0; l < 4; l++) begin
      apb(1'h1, 8'h08, l);
      chk(lvl, l);
      apb(1'h0, 8'h08, 32'h0);
      chk(rd, l);
    end
    apb(1'h1, 8'h00, 32'hFFFF_FFFF);
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h1F1F_FFFF);
    apb(1'h0, 8'h10, 32'h0);
    chk(er, 1'h1);
    chk(rd, 32'h0);
  endtask
  task automatic t_seq(input logic s, input int p, input logic [4:0] on_c, input logic [4:0] off_c);
    ws = s;
    wp = p;
    go(1'h1);
    run(5'h0A, 2, 1'h1);
    run(on_c, 3, 1'h1);
    run(5'h10, 4, 1'h1);
    go(1'h0);
    run(5'h0C, 1, 1'h0);
    run(off_c, 2, 1'h0);
    run(5'h10, 3, 1'h0);
  endtask
  task automatic t_abort;
    ws = 1'h0;
    wp = 0;
    @(posedge clk_sys);
    hs_req[0] <= 1'h1;
    @(posedge clk_sys);
    hs_req[0] <= 1'h0;
    @(posedge clk_sys);
    #1;
    run(5'h0A, 1, 1'h1);
    run(5'h0C, 1, 1'h0);
    run(5'h05, 2, 1'h0);
  endtask
  task automatic t_pre;
    cfg(32'h0C10_9653, 32'h0201_0302);
    ws = 1'h0;
    wp = 1;
    go(1'h1);
    run(5'h10, 2, 1'h1);
    run(5'h03, 3, 1'h1);
    apb(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h0000_0202);
    go(1'h0);
    repeat (6) @(posedge clk_sys);
    cfg(32'h0C10_9653, 32'h0201_0300);
    go(1'h1);
    run(5'h03, 3, 1'h1);
    run(5'h10, 1, 1'h1);
    go(1'h0);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      print_verdict;
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'h1;
    t_regs;
    cfg(32'h0C0A_9653, 32'h0201_0302);
    t_seq(1'h0, 0, 5'h03, 5'h05);
    t_seq(1'h1, 2, 5'h06, 5'h09);
    t_abort;
    t_pre;
    print_verdict;
  end
endmodule // testbench
